// ### src/usf_pkg.sv
// Shared constants and types of the serial frame transceiver.
// Assumes one 20 MHz clock; all configuration arrives as plain ports.
//
// What this block does
// (R1) One low start bit opens each frame
// (R2) Five to nine data bits per frame
// (R3) Parity sits after data, before stop
// (R4) Parity none, even or odd; generated, checked
// (R5) One or two high stop bits
// (R6) Next frame follows at once or line idles high
// (R7) Bit clock from baud generator or transfer clock
// (R8) Divisor: six fraction bits, upper bits integer
// (R9) Fraction stretches periods; average follows divisor
// (R10) Software keeps divisor within 64 to 65535
// (R11) Sync master uses integer field only
// (R12) Single transmit holding buffer feeds shifter
// (R13) Receive shifter feeds two-entry status buffer
// (R14) Timely refill gives back-to-back frames
// (R15) Transfer clock pin and RS-485 drive enable
// (R16) Loopback makes transmit pin the receive line
// (R17) Open drain makes transmit pin output automatically
// (R18) Software sets divisor, format, pin, then enables
// (R19) Software avoids reconfiguring during transmission
// (R20) Separate transmit-complete, buffer-empty, receive-complete flags
// (R21) False start rejection and low-pass filter
// (R22) Overflow and framing errors flagged per character
// (R23) Samples per bit: sixteen, eight or two
// (R24) Transmit complete when shifter and buffer empty
// (R25) Software writes data only when buffer empty
// (R26) LSB first; parity counts ones even or odd
// (R27) Fraction accumulates; overflow adds one clock

package usf_pkg;

  localparam int DATA_W = 9;
  localparam int BAUD_W = 16;
  localparam int FRAC_W = 6;
  localparam int INT_W = 10;

  // Samples per bit for each operating mode
  localparam logic [4:0] SAMP_NORMAL = 5'h10;
  localparam logic [4:0] SAMP_DOUBLE = 5'h08;
  localparam logic [4:0] SAMP_SYNC = 5'h02;

  // Character size code 0..4 means 5..9 bits
  localparam logic [3:0] CHSZ_BASE = 4'h5;
  localparam logic [3:0] DATA_MAX = 4'h9;

  // Line levels
  localparam logic LVL_IDLE = 1'b1;
  localparam logic LVL_START = 1'b0;
  localparam logic LVL_STOP = 1'b1;

  // Reset values
  localparam logic [INT_W-1:0] RST_DIV = 10'h000;
  localparam logic [FRAC_W-1:0] RST_FRAC = 6'h00;
  localparam logic [2:0] RST_HIST = 3'h7;

  typedef enum logic [1:0] {USF_PAR_NONE, USF_PAR_EVEN, USF_PAR_ODD} usf_parity_t;

  typedef struct packed {
    logic ovf;
    logic perr;
    logic ferr;
    logic [DATA_W-1:0] data;
  } usf_rx_word_t;

endpackage : usf_pkg

// ### src/usf_rx_if.sv
// Valid/ready carrier for received characters with their status.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps

interface usf_rx_if;
  logic valid;
  logic ready;
  usf_pkg::usf_rx_word_t word;

  modport src (output valid, output word, input ready);
  modport snk (input valid, input word, output ready);
endinterface : usf_rx_if

// ### src/usf_rx_buf.sv
// Two-entry receive buffer, head entry presented from flip-flops.
// Assumes a single clock and synchronous active-high reset.
`timescale 1ns/10ps

module usf_rx_buf (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  input wire logic flush,
  // Filling side
  usf_rx_if.snk in_p,
  // Draining side
  usf_rx_if.src out_p
);
  import usf_pkg::*;

  usf_rx_word_t ent0_r;
  usf_rx_word_t ent1_r;
  logic vld0_r;
  logic vld1_r;
  logic pop;
  logic push;

  assign pop = vld0_r & out_p.ready;
  assign push = in_p.valid & ~vld1_r;
  assign in_p.ready = ~vld1_r;
  assign out_p.valid = vld0_r;
  assign out_p.word = ent0_r;

  // (R13) two-entry shift buffer
  always_ff @(posedge clk)
  begin
    if (srst || flush)
    begin
      vld0_r <= 1'b0;
      vld1_r <= 1'b0;
    end
    else
    begin
      if (pop)
      begin
        ent0_r <= ent1_r;
        vld0_r <= vld1_r;
        vld1_r <= 1'b0;
      end
      if (push)
      begin
        if (pop ? ~vld1_r : ~vld0_r)
        begin
          ent0_r <= in_p.word;
          vld0_r <= 1'b1;
        end
        else
        begin
          ent1_r <= in_p.word;
          vld1_r <= 1'b1;
        end
      end
    end
  end

endmodule : usf_rx_buf

// ### src/usf_top.sv
// Serial transceiver: frame format, fractional baud generator, buffers.
// Assumes pins and configuration are synchronous to clk.
`timescale 1ns/10ps

module usf_top (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Configuration
  input wire logic [usf_pkg::BAUD_W-1:0] baud_div,
  input wire logic [2:0] char_size,
  input wire usf_pkg::usf_parity_t parity_mode,
  input wire logic two_stop,
  input wire logic sync_mode,
  input wire logic sync_master,
  input wire logic double_speed,
  input wire logic rs485_mode,
  input wire logic loopback_enable,
  input wire logic open_drain_enable,
  input wire logic tx_enable,
  input wire logic rx_enable,
  // Transmit data port
  input wire logic [usf_pkg::DATA_W-1:0] tx_data_register,
  input wire logic tx_write,
  input wire logic tx_complete_clear,
  output logic tx_buffer_empty_flag,
  output logic tx_complete_flag,
  // Receive data port
  input wire logic rx_read,
  output logic rx_complete_flag,
  output logic [usf_pkg::DATA_W-1:0] rx_data,
  output logic rx_frame_error,
  output logic rx_parity_error,
  output logic rx_overflow,
  // Transmit pin, two-way
  input wire logic txd_i,
  output logic txd_o,
  output logic txd_oe,
  // Receive pin
  input wire logic rxd_i,
  // Transfer clock pin, two-way
  input wire logic sync_transfer_clock_i,
  output logic sync_transfer_clock_o,
  output logic sync_transfer_clock_oe,
  // RS-485 driver control
  output logic rs485_drive_enable
);
  import usf_pkg::*;

  typedef enum logic [2:0] {
    USF_TX_IDLE, USF_TX_START, USF_TX_DATA, USF_TX_PAR, USF_TX_STOP1, USF_TX_STOP2
  } usf_tx_state_t;

  typedef enum logic [2:0] {
    USF_RX_IDLE, USF_RX_START, USF_RX_DATA, USF_RX_PAR, USF_RX_STOP
  } usf_rx_state_t;

  function automatic logic [DATA_W-1:0] usf_mask(input logic [DATA_W-1:0] d,
                                                 input logic [3:0] n);
    logic [DATA_W-1:0] m;
    m = '0;
    for (int i = 0; i < DATA_W; i++)
      m[i] = d[i] & (4'(i) < n);
    return m;
  endfunction : usf_mask

  // Baud generator
  logic [INT_W-1:0] div_cnt_r;
  logic [FRAC_W-1:0] frac_acc_r;
  logic [INT_W-1:0] baud_int;
  logic [FRAC_W-1:0] baud_frac;
  logic [FRAC_W:0] acc_sum;
  logic samp_tick;
  logic [4:0] samp_per_bit;
  logic [3:0] last_samp;
  logic [3:0] half_samp;

  // Transfer clock
  logic xck_o_r;
  logic xck_oe_r;
  logic xck_in_r;
  logic xck_prev_r;
  logic is_master;
  logic xck_rise;
  logic xck_fall;

  // Transmitter
  usf_tx_state_t tx_state_r;
  logic [DATA_W-1:0] tx_hold_r;
  logic tx_empty_r;
  logic [DATA_W-1:0] tx_shift_r;
  logic [3:0] tx_idx_r;
  logic tx_par_r;
  logic [3:0] tx_os_r;
  logic tx_bit_tick;
  logic tx_last_stop;
  logic tx_load;
  logic tx_line;
  logic [DATA_W-1:0] tx_masked;
  logic txc_r;
  logic txd_o_r;
  logic txd_oe_r;
  logic de_r;
  logic [3:0] nbits;

  // Receiver
  usf_rx_state_t rx_state_r;
  logic [2:0] rx_hist_r;
  logic [3:0] rx_os_r;
  logic [3:0] rx_idx_r;
  logic [DATA_W-1:0] rx_shift_r;
  logic rx_par_r;
  logic rx_perr_r;
  logic rx_push_r;
  usf_rx_word_t rx_word_r;
  logic ovf_pend_r;
  logic rx_pin;
  logic rx_filt;
  logic rx_bit;
  logic rx_take;

  usf_rx_if wr_if ();
  usf_rx_if rd_if ();
  // (R2) five to nine data bits
  assign nbits = {1'b0, char_size} + CHSZ_BASE;

  // (R8) integer and fraction fields
  assign baud_int = baud_div[BAUD_W-1:FRAC_W];
  // (R11) sync uses integer field only
  assign baud_frac = sync_mode ? RST_FRAC : baud_div[FRAC_W-1:0];
  assign acc_sum = {1'b0, frac_acc_r} + {1'b0, baud_frac};
  assign samp_tick = (div_cnt_r == RST_DIV);

  // (R23) samples per bit by mode
  assign samp_per_bit = sync_mode ? SAMP_SYNC : (double_speed ? SAMP_DOUBLE : SAMP_NORMAL);
  assign last_samp = 4'(samp_per_bit - 5'h01);
  assign half_samp = 4'({1'b0, samp_per_bit[4:1]} - 5'h01);

  // (R27) fraction carry adds one clock
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      div_cnt_r <= RST_DIV;
      frac_acc_r <= RST_FRAC;
    end
    else if (samp_tick)
    begin
      // (R9) period stretched by carry
      div_cnt_r <= baud_int - 10'h001 + {9'h000, acc_sum[FRAC_W]};
      frac_acc_r <= acc_sum[FRAC_W-1:0];
    end
    else
    begin
      div_cnt_r <= div_cnt_r - 10'h001;
    end
  end

  // (R15) transfer clock pin handling
  assign is_master = sync_mode & sync_master;

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      xck_o_r <= 1'b0;
      xck_oe_r <= 1'b0;
      xck_in_r <= 1'b0;
      xck_prev_r <= 1'b0;
    end
    else
    begin
      xck_in_r <= sync_transfer_clock_i;
      xck_prev_r <= xck_in_r;
      xck_oe_r <= is_master;
      if (!is_master)
        xck_o_r <= 1'b0;
      else if (samp_tick)
        xck_o_r <= ~xck_o_r;
    end
  end

  // (R7) bit timing from generator or pin
  assign xck_rise = is_master ? (samp_tick & ~xck_o_r) : (xck_in_r & ~xck_prev_r);
  assign xck_fall = is_master ? (samp_tick & xck_o_r) : (~xck_in_r & xck_prev_r);
  assign tx_bit_tick = sync_mode ? xck_rise : (samp_tick && tx_os_r == last_samp);

  always_ff @(posedge clk)
  begin
    if (srst || sync_mode)
      tx_os_r <= 4'h0;
    else if (samp_tick)
      tx_os_r <= (tx_os_r == last_samp) ? 4'h0 : tx_os_r + 4'h1;
  end

  // (R12) single holding buffer
  assign tx_masked = usf_mask(tx_hold_r, nbits);
  assign tx_last_stop = (tx_state_r == USF_TX_STOP1 && !two_stop) || tx_state_r == USF_TX_STOP2;
  // (R14) reload straight after last stop
  assign tx_load = tx_bit_tick && !tx_empty_r && tx_enable
                   && (tx_state_r == USF_TX_IDLE || tx_last_stop);

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      tx_empty_r <= 1'b1;
    end
    // (R25) writes only land when empty
    else if (tx_write && tx_empty_r)
    begin
      tx_hold_r <= tx_data_register;
      tx_empty_r <= 1'b0;
    end
    else if (tx_load)
    begin
      tx_empty_r <= 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      tx_state_r <= USF_TX_IDLE;
      tx_idx_r <= 4'h0;
    end
    else if (tx_load)
    begin
      // (R26) parity over masked data
      tx_shift_r <= tx_masked;
      tx_par_r <= (^tx_masked) ^ (parity_mode == USF_PAR_ODD);
      tx_state_r <= USF_TX_START;
    end
    else if (tx_bit_tick)
    begin
      case (tx_state_r)
        USF_TX_START:
        begin
          tx_state_r <= USF_TX_DATA;
          tx_idx_r <= 4'h0;
        end
        USF_TX_DATA:
        begin
          // (R26) shift out LSB first
          tx_shift_r <= tx_shift_r >> 1;
          tx_idx_r <= tx_idx_r + 4'h1;
          // (R3) parity after last data bit
          if (tx_idx_r == nbits - 4'h1)
            tx_state_r <= (parity_mode != USF_PAR_NONE) ? USF_TX_PAR : USF_TX_STOP1;
        end
        USF_TX_PAR: tx_state_r <= USF_TX_STOP1;
        // (R5) one or two stop bits
        USF_TX_STOP1: tx_state_r <= two_stop ? USF_TX_STOP2 : USF_TX_IDLE;
        USF_TX_STOP2: tx_state_r <= USF_TX_IDLE;
        default: tx_state_r <= USF_TX_IDLE;
      endcase
    end
  end

  // (R1) start low, then data
  always_comb
  begin
    case (tx_state_r)
      USF_TX_START: tx_line = LVL_START;
      USF_TX_DATA: tx_line = tx_shift_r[0];
      USF_TX_PAR: tx_line = tx_par_r;
      USF_TX_STOP1: tx_line = LVL_STOP;
      USF_TX_STOP2: tx_line = LVL_STOP;
      // (R6) idle level high
      default: tx_line = LVL_IDLE;
    endcase
  end

  // (R24) complete once shifter and buffer drained
  always_ff @(posedge clk)
  begin
    if (srst)
      txc_r <= 1'b0;
    else if (tx_bit_tick && tx_last_stop && !tx_load)
      txc_r <= 1'b1;
    else if (tx_complete_clear)
      txc_r <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      txd_o_r <= LVL_IDLE;
      txd_oe_r <= 1'b0;
      de_r <= 1'b0;
    end
    else
    begin
      // (R17) open drain drives low only
      txd_o_r <= open_drain_enable ? 1'b0 : tx_line;
      txd_oe_r <= (tx_enable || tx_state_r != USF_TX_IDLE)
                  && (!open_drain_enable || !tx_line);
      // (R15) drive enable while sending
      de_r <= rs485_mode && tx_state_r != USF_TX_IDLE;
    end
  end

  // (R16) loopback reads the transmit pin
  assign rx_pin = loopback_enable ? txd_i : rxd_i;
  // (R21) three-sample majority filter
  assign rx_filt = (rx_hist_r[0] & rx_hist_r[1]) | (rx_hist_r[1] & rx_hist_r[2])
                   | (rx_hist_r[0] & rx_hist_r[2]);
  assign rx_bit = sync_mode ? rx_pin : rx_filt;
  assign rx_take = sync_mode ? xck_fall : (samp_tick && rx_os_r == last_samp);

  always_ff @(posedge clk)
  begin
    if (srst)
      rx_hist_r <= RST_HIST;
    else if (samp_tick)
      rx_hist_r <= {rx_hist_r[1:0], rx_pin};
  end

  always_ff @(posedge clk)
  begin
    if (srst || !rx_enable)
    begin
      rx_state_r <= USF_RX_IDLE;
      rx_os_r <= 4'h0;
      rx_push_r <= 1'b0;
    end
    else
    begin
      rx_push_r <= 1'b0;
      if (samp_tick && !sync_mode)
        rx_os_r <= (rx_os_r == last_samp) ? 4'h0 : rx_os_r + 4'h1;
      case (rx_state_r)
        USF_RX_IDLE:
        begin
          rx_idx_r <= 4'h0;
          rx_par_r <= 1'b0;
          rx_perr_r <= 1'b0;
          if (sync_mode ? (xck_fall && !rx_pin) : (samp_tick && !rx_filt))
          begin
            rx_state_r <= sync_mode ? USF_RX_DATA : USF_RX_START;
            rx_os_r <= 4'h0;
          end
        end
        USF_RX_START:
        begin
          // (R21) reject false start bits
          if (samp_tick && rx_os_r == half_samp)
          begin
            rx_state_r <= rx_filt ? USF_RX_IDLE : USF_RX_DATA;
            rx_os_r <= 4'h0;
          end
        end
        USF_RX_DATA:
        begin
          if (rx_take)
          begin
            rx_shift_r <= {rx_bit, rx_shift_r[DATA_W-1:1]};
            rx_par_r <= rx_par_r ^ rx_bit;
            rx_idx_r <= rx_idx_r + 4'h1;
            if (rx_idx_r == nbits - 4'h1)
              rx_state_r <= (parity_mode != USF_PAR_NONE) ? USF_RX_PAR : USF_RX_STOP;
          end
        end
        USF_RX_PAR:
        begin
          // (R4) check received parity
          if (rx_take)
          begin
            rx_perr_r <= rx_par_r ^ rx_bit ^ (parity_mode == USF_PAR_ODD);
            rx_state_r <= USF_RX_STOP;
          end
        end
        USF_RX_STOP:
        begin
          if (rx_take)
          begin
            rx_word_r.data <= rx_shift_r >> (DATA_MAX - nbits);
            // (R22) framing error on low stop
            rx_word_r.ferr <= ~rx_bit;
            rx_word_r.perr <= rx_perr_r;
            rx_word_r.ovf <= ovf_pend_r;
            rx_push_r <= 1'b1;
            rx_state_r <= USF_RX_IDLE;
          end
        end
        default: rx_state_r <= USF_RX_IDLE;
      endcase
    end
  end

  // (R22) lost character marks the next one
  always_ff @(posedge clk)
  begin
    if (srst || !rx_enable)
      ovf_pend_r <= 1'b0;
    else if (rx_push_r && !wr_if.ready)
      ovf_pend_r <= 1'b1;
    else if (rx_push_r)
      ovf_pend_r <= 1'b0;
  end

  assign wr_if.valid = rx_push_r;
  assign wr_if.word = rx_word_r;
  assign rd_if.ready = rx_read;

  // (R13) receive buffer with per-character status
  usf_rx_buf u_rx_buf (
    .clk (clk),
    .srst (srst),
    .flush (!rx_enable),
    .in_p (wr_if.snk),
    .out_p (rd_if.src)
  );

  // (R20) separate event flags
  assign tx_buffer_empty_flag = tx_empty_r;
  assign tx_complete_flag = txc_r;
  assign rx_complete_flag = rd_if.valid;
  assign rx_data = rd_if.word.data;
  assign rx_frame_error = rd_if.word.ferr;
  assign rx_parity_error = rd_if.word.perr;
  assign rx_overflow = rd_if.word.ovf;
  assign txd_o = txd_o_r;
  assign txd_oe = txd_oe_r;
  assign sync_transfer_clock_o = xck_o_r;
  assign sync_transfer_clock_oe = xck_oe_r;
  assign rs485_drive_enable = de_r;

endmodule : usf_top

// ### test/usf_line_node.sv
// Remote serial node at the far end of the line.
// Assumes the bench gives bit times in clk cycles; drives its line idle high.
`timescale 1ns/10ps

module usf_line_node (
  // Clock
  input wire logic clk,
  // Line driven by the device
  input wire logic line,
  // Line towards the device
  output logic rxd
);
  initial rxd = 1'b1;

  // Plays nb levels from bit 0, each bt clocks, then idles one bit
  task automatic send(input logic [12:0] v, input int nb, input int bt);
    @(posedge clk);
    for (int i = 0; i <= nb; i++)
    begin
      #1 rxd = (i < nb) ? v[i] : 1'b1;
      repeat (bt) @(posedge clk);
    end
  endtask : send

  // Waits for a start edge, samples nb bits mid-bit, returns at last sample
  task automatic recv(output logic [12:0] v, output int gap, input int nb, input int bt);
    v = '0;
    gap = 0;
    while (line !== 1'b0 && gap < 5000)
    begin
      @(negedge clk);
      gap++;
    end
    repeat (bt / 2) @(negedge clk);
    for (int i = 0; i < nb; i++)
    begin
      if (i > 0)
        repeat (bt) @(negedge clk);
      v[i] = line;
    end
  endtask : recv
endmodule : usf_line_node

// ### test/usf_top_assertions.sv
// Concurrent checks on the serial transceiver top ports.
// Assumes it is bound to usf_top and shares its clock and reset.
`timescale 1ns/10ps

module usf_top_assertions (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Transmit side
  input wire logic tx_write,
  input wire logic tx_buffer_empty_flag,
  input wire logic tx_complete_flag,
  input wire logic txd_o,
  input wire logic txd_oe,
  input wire logic open_drain_enable,
  // Pin roles and receive side
  input wire logic rs485_mode,
  input wire logic rs485_drive_enable,
  input wire logic sync_mode,
  input wire logic sync_transfer_clock_oe,
  input wire logic rx_enable,
  input wire logic rx_complete_flag
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  property p_write_fills;
    tx_write && tx_buffer_empty_flag |=> !tx_buffer_empty_flag;
  endproperty
  a_write_fills: assert property (p_write_fills)
    else $error("accepted write left buffer empty");

  property p_start_low;
    $rose(tx_buffer_empty_flag) && !open_drain_enable |=> !txd_o;
  endproperty
  a_start_low: assert property (p_start_low)
    else $error("frame did not open low");

  property p_stop_high;
    $rose(tx_complete_flag) && !open_drain_enable |-> txd_o;
  endproperty
  a_stop_high: assert property (p_stop_high)
    else $error("line not high at frame end");

  property p_done_empty;
    $rose(tx_complete_flag) |-> tx_buffer_empty_flag;
  endproperty
  a_done_empty: assert property (p_done_empty)
    else $error("complete while data pending");

  property p_od_low;
    open_drain_enable && $past(open_drain_enable) && txd_oe |-> !txd_o;
  endproperty
  a_od_low: assert property (p_od_low)
    else $error("open drain drove high");

  property p_drive_on_low;
    rs485_mode && txd_oe && !txd_o |-> ##[0:1] rs485_drive_enable;
  endproperty
  a_drive_on_low: assert property (p_drive_on_low)
    else $error("drive enable low during frame");

  property p_rx_flush;
    !rx_enable |=> !rx_complete_flag;
  endproperty
  a_rx_flush: assert property (p_rx_flush)
    else $error("receive buffer kept after disable");

  property p_sync_oe;
    !sync_mode && !$past(sync_mode) |-> !sync_transfer_clock_oe;
  endproperty
  a_sync_oe: assert property (p_sync_oe)
    else $error("transfer clock driven in async mode");
endmodule : usf_top_assertions

bind usf_top usf_top_assertions u_usf_chk (
  .clk, .srst, .tx_write, .tx_buffer_empty_flag, .tx_complete_flag, .txd_o, .txd_oe,
  .open_drain_enable, .rs485_mode, .rs485_drive_enable, .sync_mode,
  .sync_transfer_clock_oe, .rx_enable, .rx_complete_flag
);

// ### test/usf_top_tb.sv
// Self-checking bench for the serial transceiver top.
// Assumes the line node model and the bound checker are compiled first.
`timescale 1ns/10ps

module usf_top_tb;
  import usf_pkg::*;

  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [BAUD_W-1:0] baud_div = 16'h0080;
  logic [2:0] char_size = 3'h3;
  usf_parity_t parity_mode = USF_PAR_NONE;
  logic two_stop = 1'b0, sync_mode = 1'b0, sync_master = 1'b0, double_speed = 1'b0;
  logic rs485_mode = 1'b0, loopback_enable = 1'b0, open_drain_enable = 1'b0;
  logic tx_enable = 1'b0, rx_enable = 1'b0, tx_write = 1'b0, tx_complete_clear = 1'b0;
  logic rx_read = 1'b0, sync_transfer_clock_i = 1'b0;
  logic [DATA_W-1:0] tx_data_register = 9'h000;
  logic [DATA_W-1:0] rx_data;
  logic tx_buffer_empty_flag, tx_complete_flag, rx_complete_flag, rx_frame_error;
  logic rx_parity_error, rx_overflow, txd_o, txd_oe, sync_transfer_clock_o;
  logic sync_transfer_clock_oe, rs485_drive_enable, node_rxd, txd_line;
  int mismatches = 0;
  int check_count = 0;

  // Pulled-up transmit wire
  assign txd_line = txd_oe ? txd_o : 1'b1;
  always #25 clk = ~clk;

  usf_top dut (
    .clk, .srst, .baud_div, .char_size, .parity_mode, .two_stop, .sync_mode, .sync_master,
    .double_speed, .rs485_mode, .loopback_enable, .open_drain_enable, .tx_enable,
    .rx_enable, .tx_data_register, .tx_write, .tx_complete_clear, .tx_buffer_empty_flag,
    .tx_complete_flag, .rx_read, .rx_complete_flag, .rx_data, .rx_frame_error,
    .rx_parity_error, .rx_overflow, .txd_i(txd_line), .txd_o, .txd_oe, .rxd_i(node_rxd),
    .sync_transfer_clock_i, .sync_transfer_clock_o, .sync_transfer_clock_oe,
    .rs485_drive_enable
  );
  usf_line_node node (.clk(clk), .line(txd_line), .rxd(node_rxd));

  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : stop_test

  task automatic chk(input string nm, input logic [12:0] e, input logic [12:0] g);
    check_count++;
    if (g !== e)
    begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic tmo(input int t);
    if (t > 4000)
    begin
      mismatches++;
      stop_test();
    end
  endtask : tmo

  // even or odd count; levels bit 0 first
  function automatic logic [12:0] frame(input logic [8:0] d, input int n, input int par,
                                        input int ns);
    logic [12:0] v;
    v = '0;
    for (int i = 0; i < n; i++)
      v[1 + i] = d[i];
    if (par != 0)
      v[1 + n] = (^v) ^ (par == 2);
    v[1 + n + (par != 0)] = 1'b1;
    v[2 + n + (par != 0)] = (ns == 2);
    return v;
  endfunction : frame

  // divisor, format, then enables, only while idle
  task automatic cfg(input logic [15:0] bd, input int cs, input int par, input int ns,
                     input logic [5:0] md);
    repeat (64) @(posedge clk);
    #1 tx_enable = 1'b0;
    rx_enable = 1'b0;
    baud_div = bd;
    char_size = 3'(cs);
    parity_mode = usf_parity_t'(par);
    two_stop = (ns == 2);
    {sync_mode, sync_master, double_speed, rs485_mode, loopback_enable, open_drain_enable} = md;
    @(posedge clk);
    #1 tx_enable = 1'b1;
    rx_enable = 1'b1;
  endtask : cfg

  // wait for an empty buffer unless probing a refused write
  task automatic wr(input logic [8:0] d, input logic force_w);
    int t;
    t = 0;
    @(posedge clk);
    #1 while (tx_buffer_empty_flag !== 1'b1 && !force_w)
    begin
      @(posedge clk);
      #1 t++;
      tmo(t);
    end
    tx_write = 1'b1;
    tx_data_register = d;
    @(posedge clk);
    #1 tx_write = 1'b0;
  endtask : wr

  task automatic rd(input logic [11:0] e);
    int t;
    t = 0;
    @(posedge clk);
    #1 while (rx_complete_flag !== 1'b1)
    begin
      @(posedge clk);
      #1 t++;
      tmo(t);
    end
    chk("rx word", 13'(e), 13'({rx_overflow, rx_parity_error, rx_frame_error, rx_data}));
    rx_read = 1'b1;
    @(posedge clk);
    #1 rx_read = 1'b0;
  endtask : rd

  task automatic t_reset();
    chk("idle line", 13'h1, 13'(txd_o));
    chk("flags", 13'h4, 13'({tx_buffer_empty_flag, tx_complete_flag, rx_complete_flag}));
  endtask : t_reset

  task automatic t_formats();
    logic [12:0] v;
    int gap;
    for (int k = 0; k < 5; k++)
    begin
      cfg(16'h0080, k, k % 3, 1 + k % 2, 6'h00);
      wr(9'h155 ^ 9'(k * 83), 1'b0);
      node.recv(v, gap, k + 7 + (k % 3 != 0) + k % 2, 32);
      tmo(gap);
      chk("tx frame", frame(9'h155 ^ 9'(k * 83), k + 5, k % 3, 1 + k % 2), v);
    end
  endtask : t_formats

  task automatic t_back2back();
    logic [12:0] v;
    int gap;
    cfg(16'h0080, 3, 0, 1, 6'h00);
    tx_complete_clear = 1'b1;
    @(posedge clk);
    #1 tx_complete_clear = 1'b0;
    chk("done cleared", 13'h0, 13'(tx_complete_flag));
    wr(9'h0a5, 1'b0);
    wr(9'h05a, 1'b0);
    wr(9'h1ff, 1'b1);
    node.recv(v, gap, 10, 32);
    tmo(gap);
    chk("first", frame(9'h0a5, 8, 0, 1), v);
    node.recv(v, gap, 10, 32);
    tmo(gap);
    chk("second", frame(9'h05a, 8, 0, 1), v);
    chk("gap", 13'h1, 13'(gap <= 20));
    chk("done early", 13'h0, 13'(tx_complete_flag));
    repeat (40) @(negedge clk);
    chk("done and idle", 13'h3, 13'({tx_complete_flag, txd_line}));
  endtask : t_back2back

  task automatic t_rx();
    logic [12:0] v;
    cfg(16'h0080, 2, 1, 1, 6'h00);
    v = frame(9'h05b, 7, 1, 1);
    node.send(v, 10, 32);
    node.send(v ^ 13'h100, 10, 32);
    node.send(v, 10, 32);
    rd(12'h05b);
    rd(12'h45b);
    node.send(frame(9'h033, 7, 1, 1) & ~13'h200, 10, 32);
    rd(12'ha33);
    repeat (64) @(negedge clk);
    chk("rx empty", 13'h0, 13'(rx_complete_flag));
  endtask : t_rx

  task automatic t_modes();
    logic [12:0] v;
    int gap;
    cfg(16'h0080, 3, 0, 1, 6'h07);
    wr(9'h0c6, 1'b0);
    node.recv(v, gap, 10, 32);
    tmo(gap);
    chk("one wire", frame(9'h0c6, 8, 0, 1), v);
    chk("drive enable", 13'h1, 13'(rs485_drive_enable));
    rd(12'h0c6);
  endtask : t_modes

  task automatic t_frac();
    int n;
    for (int ds = 0; ds < 2; ds++)
    begin
      cfg(16'h00a0, 3, 0, 1, 6'(ds * 8));
      wr(9'h000, 1'b0);
      n = 0;
      while (txd_line !== 1'b0 && n <= 4000)
      begin
        @(negedge clk);
        n++;
      end
      tmo(n);
      n = 0;
      while (txd_line === 1'b0 && n <= 4000)
      begin
        @(negedge clk);
        n++;
      end
      tmo(n);
      chk("low time", 13'h1, 13'(n >= 359 - ds * 180 && n <= 361 - ds * 180));
    end
  endtask : t_frac

  task automatic t_sync();
    logic [12:0] v;
    int gap;
    int n;
    cfg(16'h0100, 3, 0, 1, 6'h30);
    wr(9'h13c, 1'b0);
    n = 0;
    fork
      node.recv(v, gap, 10, 8);
      begin
        // Align to a full high phase first
        while (sync_transfer_clock_o !== 1'b0 && n <= 4000)
        begin
          @(negedge clk);
          n++;
        end
        while (sync_transfer_clock_o !== 1'b1 && n <= 4000)
        begin
          @(negedge clk);
          n++;
        end
        n = 0;
        while (sync_transfer_clock_o === 1'b1 && n <= 4000)
        begin
          @(negedge clk);
          n++;
        end
        while (sync_transfer_clock_o !== 1'b1 && n <= 4000)
        begin
          @(negedge clk);
          n++;
        end
      end
    join
    tmo(gap);
    tmo(n);
    chk("sync frame", frame(9'h13c, 8, 0, 1), v);
    chk("clock period", 13'h8, 13'(n));
    chk("clock drive", 13'h1, 13'(sync_transfer_clock_oe));
  endtask : t_sync

  // Slave: transfer clock comes from the pin, eight clocks a period
  task automatic t_slave();
    logic [12:0] v;
    int gap;
    cfg(16'h0100, 3, 0, 1, 6'h20);
    fork
      repeat (200)
      begin
        repeat (4) @(posedge clk);
        #1 sync_transfer_clock_i = ~sync_transfer_clock_i;
      end
      begin
        wr(9'h0e1, 1'b0);
        node.recv(v, gap, 10, 8);
      end
    join
    tmo(gap);
    chk("slave frame", frame(9'h0e1, 8, 0, 1), v);
  endtask : t_slave

  initial
  begin
    repeat (4) @(posedge clk);
    #1 srst = 1'b0;
    t_reset();
    t_formats();
    t_back2back();
    t_rx();
    t_modes();
    t_frac();
    t_sync();
    t_slave();
    stop_test();
  end
endmodule : usf_top_tb
